/* design/fwdl_cmd.sv */
`timescale 1ns/1ns
module fwdl_cmd
  import fwdl_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             cmd_valid,
  input  wire logic [7:0]       cmd_code,
  input  wire logic [7:0]       cmd_feature,
  input  wire logic [7:0]       cmd_sec_count,
  input  wire logic [7:0]       cmd_sec_number,
  input  wire logic [7:0]       cmd_cyl_low,
  input  wire logic [7:0]       cmd_cyl_high,
  input  wire logic             security_locked,
  input  wire logic             spinup_disabled,
  input  wire logic [7:0]       diag_code,
  input  wire logic [WIDTH-1:0] dma_data,
  input  wire logic             dma_valid,
  output logic                  dma_ready,
  output logic [WIDTH-1:0]      image_data,
  output logic                  image_valid,
  input  wire logic             image_ready,
  output logic                  image_discard,
  input  wire logic             reload_request,
  input  wire logic             reload_fail,
  output logic                  image_commit,
  output logic                  spin_down,
  output logic                  other_cmd_start,
  output logic [7:0]            command_error_flags,
  output logic [7:0]            device_status_flags
);
  // ==========================================================
  // State
  localparam int FW = $clog2(DEPTH) + 1;
  typedef struct packed {
    fwdl_state_e state;
    logic [22:0] words_left;
    logic [FW-1:0] fill;
    logic        last_seg;
    logic [2:0]  verify_cnt;
    logic        dma_ready;
    logic        discard;
    logic        commit;
    logic        spin_down;
    logic        other;
    logic [7:0]  err;
    logic [7:0]  status;
  } fwdl_cmd_s;
  fwdl_cmd_s q;
  fwdl_cmd_s next_q;

  logic [WIDTH-1:0] f_data;
  logic             f_valid;
  logic             f_in_ready;
  logic             f_out_ready;
  logic             seg_in_order;
  logic             seg_active;
  logic             seg_clear;
  logic             seg_accept;
  logic [15:0]      blocks;
  logic [15:0]      seg_offset;
  logic             is_dl;
  logic             feat_ok;
  logic             push;
  logic             pop;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;

  // ==========================================================
  // Decode
  assign blocks     = fwdl_join(cmd_sec_number, cmd_sec_count);
  assign is_dl      = cmd_valid && (cmd_code == CMD_DL_DMA);
  assign feat_ok    = (cmd_feature == SUB_OFFSET) || (cmd_feature == SUB_ONE_PASS);
  // The single-pass form always counts as a fresh image at offset zero.
  assign seg_offset = (cmd_feature == SUB_OFFSET) ? {cmd_cyl_high, cmd_cyl_low} : 16'h0000;
  assign push       = q.dma_ready && dma_valid && f_in_ready;
  assign pop        = f_valid && f_out_ready;
  assign f_out_ready = !out_valid_q || image_ready;
  assign seg_accept = is_dl && (q.state == FWDL_IDLE) && feat_ok && !security_locked
                      && seg_in_order && (cmd_feature == SUB_OFFSET);
  assign seg_clear  = next_q.discard || next_q.commit;

  fwdl_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_data   (dma_data),
    .in_valid  (q.dma_ready && dma_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_out_ready)
  );

  fwdl_seg_check u_seg (
    .core_clk (core_clk),
    .reset    (reset),
    .clear    (seg_clear),
    .accept   (seg_accept),
    .offset   (seg_offset),
    .blocks   (blocks),
    .in_order (seg_in_order),
    .active   (seg_active)
  );

  // ==========================================================
  // Command sequencing
  always_comb begin
    next_q           = q;
    next_q.discard   = 1'b0;
    next_q.commit    = 1'b0;
    next_q.spin_down = 1'b0;
    next_q.other     = 1'b0;
    // The shadow fill level mirrors the FIFO so ready can be decided a cycle early.
    next_q.fill      = q.fill + FW'(push) - FW'(pop);
    unique case (q.state)
      FWDL_IDLE: begin
        if (is_dl) begin
          next_q.err = ERR_RESET;
          next_q.status[ST_BSY_BIT] = 1'b1;
          next_q.status[ST_RDY_BIT] = 1'b0;
          next_q.status[ST_ERR_BIT] = 1'b0;
          next_q.last_seg = (cmd_feature == SUB_ONE_PASS);
          // Only the offset form is held to the segment sequence; single pass starts afresh.
          if (!feat_ok || security_locked || (cmd_feature == SUB_OFFSET && !seg_in_order)) begin
            next_q.err[ERR_ABT_BIT] = 1'b1;
            next_q.discard = 1'b1;
            next_q.state   = FWDL_FINISH;
          end else if (blocks == 16'h0000) begin
            next_q.state = next_q.last_seg ? FWDL_VERIFY : FWDL_FINISH;
          end else begin
            next_q.words_left = {blocks, 7'h00};
            next_q.dma_ready  = 1'b1;
            next_q.status[ST_DRQ_BIT] = 1'b1;
            next_q.state = FWDL_XFER;
          end
        end else if (cmd_valid) begin
          next_q.other = 1'b1;
          next_q.discard = seg_active;
          if (cmd_code == CMD_DIAG) begin
            next_q.err = diag_code;
            next_q.status[ST_ERR_BIT] = 1'b0;
          end
        end
      end
      FWDL_XFER: begin
        if (push) begin
          next_q.words_left = q.words_left - 23'h000001;
        end
        // Ready is a flop, so it stays up only while the word that may land next
        // cycle is sure of a free FIFO slot.
        next_q.dma_ready = (next_q.words_left != 23'h000000)
                           && (next_q.fill != FW'(DEPTH));
        if (next_q.words_left == 23'h000000) begin
          next_q.status[ST_DRQ_BIT] = 1'b0;
          next_q.state = FWDL_DRAIN;
        end
      end
      FWDL_DRAIN: begin
        if (!f_valid && !out_valid_q) begin
          next_q.state = q.last_seg ? FWDL_VERIFY : FWDL_FINISH;
        end
      end
      FWDL_VERIFY: begin
        next_q.verify_cnt = q.verify_cnt + 3'h1;
        if (q.verify_cnt == 3'(VERIFY_CYCLES - 1)) begin
          next_q.verify_cnt = 3'h0;
          next_q.commit = 1'b1;
          if (reload_request && reload_fail) begin
            next_q.err[ERR_UNC_BIT] = 1'b1;
          end
          next_q.spin_down = reload_request && !reload_fail && spinup_disabled;
          next_q.state = FWDL_FINISH;
        end
      end
      FWDL_FINISH: begin
        next_q.status[ST_BSY_BIT] = 1'b0;
        next_q.status[ST_DRQ_BIT] = 1'b0;
        next_q.status[ST_RDY_BIT] = 1'b1;
        next_q.status[ST_ERR_BIT] = q.err[ERR_ABT_BIT] || q.err[ERR_UNC_BIT];
        next_q.state = FWDL_IDLE;
      end
    endcase
  end

  // Output register keeps image_data from a flop while image_ready holds back-pressure.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '{state: FWDL_IDLE, err: ERR_RESET, status: STATUS_RESET, default: '0};
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else begin
      q <= next_q;
      if (f_out_ready) begin
        out_valid_q <= f_valid;
        out_data_q  <= f_data;
      end
    end
  end

  assign dma_ready           = q.dma_ready;
  assign image_data          = out_data_q;
  assign image_valid         = out_valid_q;
  assign image_discard       = q.discard;
  assign image_commit        = q.commit;
  assign spin_down           = q.spin_down;
  assign other_cmd_start     = q.other;
  assign command_error_flags = q.err;
  assign device_status_flags = q.status;

  // ==========================================================
  // Checks
  bad_feature_a: assert property (@(posedge core_clk) disable iff (reset)
    (is_dl && q.state == FWDL_IDLE && !feat_ok) |=> q.err[ERR_ABT_BIT])
    else $error("bad feature did not abort");
  lock_abort_a: assert property (@(posedge core_clk) disable iff (reset)
    (is_dl && q.state == FWDL_IDLE && security_locked) |=> q.err[ERR_ABT_BIT] ##1 q.status[ST_ERR_BIT])
    else $error("locked download did not abort");
  zero_count_a: assert property (@(posedge core_clk) disable iff (reset)
    (is_dl && q.state == FWDL_IDLE && feat_ok && !security_locked && seg_in_order
     && blocks == 16'h0000) |=> !q.dma_ready)
    else $error("zero count opened transfer");
  word_count_a: assert property (@(posedge core_clk) disable iff (reset)
    (is_dl && q.state == FWDL_IDLE && feat_ok && !security_locked && seg_in_order
     && blocks != 16'h0000) |=> q.words_left == {$past(blocks), 7'h00})
    else $error("word count wrong");
  unc_only_reload_a: assert property (@(posedge core_clk) disable iff (reset)
    (q.state == FWDL_VERIFY && !reload_request) |=> !q.err[ERR_UNC_BIT])
    else $error("unc set without reload");
  spin_cause_a: assert property (@(posedge core_clk) disable iff (reset)
    q.spin_down |-> q.commit && $past(spinup_disabled))
    else $error("spin down without cause");
  other_discard_a: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid && !is_dl && q.state == FWDL_IDLE && seg_active) |=> q.discard ##1 !seg_active)
    else $error("partial image kept");
  diag_code_a: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid && cmd_code == CMD_DIAG && q.state == FWDL_IDLE) |=> q.err == $past(diag_code))
    else $error("diagnostic code not loaded");
  finish_status_a: assert property (@(posedge core_clk) disable iff (reset)
    (q.state == FWDL_FINISH) |=> q.status[ST_RDY_BIT] && !q.status[ST_BSY_BIT]
                                  && !q.status[ST_DRQ_BIT])
    else $error("completion status wrong");
  seq_abort_a: assert property (@(posedge core_clk) disable iff (reset)
    (is_dl && q.state == FWDL_IDLE && cmd_feature == SUB_OFFSET && !seg_in_order) |=> q.discard)
    else $error("out of order segment kept");
  // Shadow fill level, back-pressure, transfer end, commit, status and segment guards.
  no_overflow_a: assert property (@(posedge core_clk) disable iff (reset)
    q.dma_ready |-> f_in_ready)
    else $error("word offered to a full fifo");
  fill_shadow_a: assert property (@(posedge core_clk) disable iff (reset)
    f_valid == (q.fill != '0))
    else $error("shadow fill level drifted");
  words_done_a: assert property (@(posedge core_clk) disable iff (reset)
    (q.state == FWDL_XFER && push && q.words_left == 23'h000001)
    |=> !q.dma_ready && q.state == FWDL_DRAIN)
    else $error("transfer did not end on last word");
  commit_last_a: assert property (@(posedge core_clk) disable iff (reset)
    q.commit |-> q.last_seg && $past(q.state) == FWDL_VERIFY)
    else $error("commit outside final segment");
  busy_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (q.state inside {FWDL_XFER, FWDL_DRAIN, FWDL_VERIFY}) |-> q.status[ST_BSY_BIT])
    else $error("busy dropped during download");
  one_pass_offset_a: assert property (@(posedge core_clk) disable iff (reset)
    (is_dl && q.state == FWDL_IDLE && cmd_feature == SUB_ONE_PASS && !security_locked)
    |=> !q.err[ERR_ABT_BIT])
    else $error("single pass aborted on offset");
  image_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (out_valid_q && !image_ready) |=> out_valid_q && $stable(out_data_q))
    else $error("image word lost under back pressure");
  discard_clears_a: assert property (@(posedge core_clk) disable iff (reset)
    q.discard |-> !seg_active)
    else $error("segment history kept after discard");

  xfer_c: cover property (@(posedge core_clk) disable iff (reset) q.state == FWDL_DRAIN);
  commit_c: cover property (@(posedge core_clk) disable iff (reset) q.commit);
  stall_c: cover property (@(posedge core_clk) disable iff (reset)
    q.state == FWDL_XFER && !q.dma_ready);
  discard_c: cover property (@(posedge core_clk) disable iff (reset) q.discard);
  diag_c: cover property (@(posedge core_clk) disable iff (reset)
    cmd_valid && cmd_code == CMD_DIAG);
endmodule

/* design/fwdl_fifo.sv */
`timescale 1ns/1ns
module fwdl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

/* design/fwdl_pkg.sv */
package fwdl_pkg;
  // ==========================================================
  // Command codes and subcommands
  localparam logic [7:0] CMD_DL_DMA     = 8'h93;
  localparam logic [7:0] CMD_DIAG       = 8'h90;
  localparam logic [7:0] SUB_OFFSET     = 8'h03;
  localparam logic [7:0] SUB_ONE_PASS   = 8'h07;
  // ==========================================================
  // Error register bit positions
  localparam int ERR_UNC_BIT = 6;
  localparam int ERR_ABT_BIT = 2;
  // ==========================================================
  // Status register bit positions
  localparam int ST_BSY_BIT = 7;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_DSC_BIT = 4;
  localparam int ST_DRQ_BIT = 3;
  localparam int ST_ERR_BIT = 0;
  // ==========================================================
  // Reset values and sizes
  localparam logic [7:0] ERR_RESET    = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam int         SECTOR_BYTES = 512;
  localparam int         SECTOR_WORDS = SECTOR_BYTES / 4;
  localparam int         VERIFY_CYCLES = 4;
  localparam int         FIFO_DEPTH   = 16;
  localparam int         WORD_W       = 32;

  typedef enum logic [2:0] {
    FWDL_IDLE,
    FWDL_XFER,
    FWDL_DRAIN,
    FWDL_VERIFY,
    FWDL_FINISH
  } fwdl_state_e;

  function automatic logic [15:0] fwdl_join(input logic [7:0] hi, input logic [7:0] lo);
    fwdl_join = {hi, lo};
  endfunction
endpackage

/* design/fwdl_seg_check.sv */
`timescale 1ns/1ns
module fwdl_seg_check
  import fwdl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clear,
  input  wire logic        accept,
  input  wire logic [15:0] offset,
  input  wire logic [15:0] blocks,
  output logic             in_order,
  output logic             active
);
  typedef struct packed {
    logic [16:0] expect_off;
    logic        active;
  } fwdl_seg_s;
  fwdl_seg_s q;
  fwdl_seg_s next_q;

  // An empty image expects offset zero; later segments must follow on directly.
  assign in_order = q.active ? ({1'b0, offset} == q.expect_off) : (offset == 16'h0000);
  assign active   = q.active;

  always_comb begin
    next_q = q;
    if (clear) begin
      next_q = '0;
    end else if (accept) begin
      next_q.expect_off = {1'b0, offset} + {1'b0, blocks};
      next_q.active     = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

/* tb/firmware_download_cmd_tb_top.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module firmware_download_cmd_tb_top
  import fwdl_pkg::*;
;
  logic core_clk, reset, cmd_valid, security_locked, spinup_disabled, image_ready;
  logic reload_request, reload_fail, load, dma_ready, dma_valid, image_valid;
  logic image_discard, image_commit, spin_down, other_cmd_start;
  logic [7:0] cmd_code, cmd_feature, cmd_sec_count, cmd_sec_number, cmd_cyl_low, cmd_cyl_high;
  logic [7:0] diag_code, command_error_flags, device_status_flags;
  logic [15:0] sectors;
  logic [31:0] dma_data, image_data, exp_word;
  int miscompares, cmp_count, cycles, n_commit, n_spin, n_disc, n_other, next_off;

  fwdl_cmd DUT (.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_feature(cmd_feature), .cmd_sec_count(cmd_sec_count), .cmd_sec_number(cmd_sec_number),
    .cmd_cyl_low(cmd_cyl_low), .cmd_cyl_high(cmd_cyl_high), .security_locked(security_locked),
    .spinup_disabled(spinup_disabled), .diag_code(diag_code), .dma_data(dma_data),
    .dma_valid(dma_valid), .dma_ready(dma_ready), .image_data(image_data),
    .image_valid(image_valid), .image_ready(image_ready), .image_discard(image_discard),
    .reload_request(reload_request), .reload_fail(reload_fail), .image_commit(image_commit),
    .spin_down(spin_down), .other_cmd_start(other_cmd_start),
    .command_error_flags(command_error_flags), .device_status_flags(device_status_flags));
  fwdl_host_dma host (.core_clk(core_clk), .reset(reset), .load(load), .sectors(sectors),
    .dma_ready(dma_ready), .dma_data(dma_data), .dma_valid(dma_valid));

  // ==========================================================
  // Clock, timeout and output monitor
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    image_ready <= ($urandom % 4) != 0;
    if (!reset) begin
      n_commit += image_commit;
      n_spin   += spin_down;
      n_disc   += image_discard;
      n_other  += other_cmd_start;
      if (image_valid && image_ready) begin
        exp_word = (host.sent_q.size() > 0) ? host.sent_q.pop_front() : ~image_data;
        `CHK(image_data, exp_word)
      end
    end
    if (cycles > 90000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    next_off = 0;
    @(negedge core_clk);
    `CHK(command_error_flags, ERR_RESET)
    `CHK(device_status_flags, STATUS_RESET)
  endtask
  task automatic env(input logic lk, input logic rq, input logic fl, input logic sp);
    @(posedge core_clk);
    security_locked <= lk;
    reload_request  <= rq;
    reload_fail     <= fl;
    spinup_disabled <= sp;
    @(negedge core_clk);
  endtask
  task automatic issue(input logic [7:0] code, input logic [7:0] feat, input logic [15:0] cnt,
                       input logic [15:0] off, input logic xfer);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    {cmd_code, cmd_feature, cmd_sec_number, cmd_sec_count} <= {code, feat, cnt};
    {cmd_cyl_high, cmd_cyl_low} <= off;
    diag_code <= 8'($urandom);
    load    <= xfer;
    sectors <= cnt;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    load      <= 1'b0;
    @(negedge core_clk);
    while (device_status_flags[ST_BSY_BIT] !== 1'b0) @(negedge core_clk);
    repeat (2) @(negedge core_clk);
  endtask
  task automatic dl(input logic [7:0] feat, input logic [15:0] cnt, input logic [15:0] off);
    logic       abt;
    logic [7:0] ee;
    int         c0, s0, d0, t0;
    abt = !(feat == SUB_OFFSET || feat == SUB_ONE_PASS) || security_locked ||
          (feat == SUB_OFFSET && int'(off) != next_off);
    {c0, s0, d0, t0} = {n_commit, n_spin, n_disc, host.taken};
    issue(CMD_DL_DMA, feat, cnt, off, !abt);
    ee = 8'h00;
    ee[ERR_ABT_BIT] = abt;
    ee[ERR_UNC_BIT] = !abt && feat == SUB_ONE_PASS && reload_request && reload_fail;
    `CHK(command_error_flags, ee)
    `CHK(device_status_flags, STATUS_RESET | {7'h00, |ee})
    `CHK(host.taken - t0, abt ? 0 : int'(cnt) * SECTOR_WORDS)
    `CHK(n_commit - c0, int'(!abt && feat == SUB_ONE_PASS))
    `CHK(n_spin - s0, int'(ee == 8'h00 && feat == SUB_ONE_PASS && reload_request &&
                          spinup_disabled))
    if (!security_locked && feat == SUB_OFFSET && int'(off) != next_off)
      `CHK(n_disc - d0, 1)
    next_off = (!abt && feat == SUB_OFFSET) ? int'(off) + int'(cnt) : 0;
  endtask

  // ==========================================================
  // Main sequence
  logic [7:0] bad_feat [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'hFF};
  initial begin
    {core_clk, reset, cmd_valid, security_locked, spinup_disabled, image_ready} = 6'h01 << 4;
    {reload_request, reload_fail, load, sectors, diag_code} = '0;
    {cmd_code, cmd_feature, cmd_sec_count, cmd_sec_number, cmd_cyl_low, cmd_cyl_high} = '0;
    {miscompares, cmp_count, cycles, n_commit, n_spin, n_disc, n_other, next_off} = '0;
    void'($urandom(32'hB776453F));
    do_reset();
    dl(SUB_ONE_PASS, 16'h0001, 16'($urandom));
    for (int i = 0; i < 8; i++) begin
      env(1'b0, i[0], i[1], i[2]);
      dl(SUB_ONE_PASS, (i == 7) ? 16'h0002 : 16'h0000, 16'h0000);
    end
    env(1'b0, 1'b0, 1'b0, 1'b0);
    foreach (bad_feat[i]) dl(bad_feat[i], 16'h0001, 16'h0000);
    env(1'b1, 1'b0, 1'b0, 1'b0);
    dl(SUB_ONE_PASS, 16'h0001, 16'h0000);
    dl(SUB_OFFSET, 16'h0000, 16'h0000);
    env(1'b0, 1'b0, 1'b0, 1'b0);
    dl(SUB_OFFSET, 16'h0100, 16'h0000);
    dl(SUB_OFFSET, 16'h0001, 16'h0100);
    dl(SUB_OFFSET, 16'h0000, 16'h0105);
    dl(SUB_OFFSET, 16'h0001, 16'h0000);
    n_other = 0;
    issue(CMD_DIAG, 8'h00, 16'h0000, 16'h0000, 1'b0);
    `CHK(command_error_flags, diag_code)
    `CHK(device_status_flags, STATUS_RESET)
    `CHK(n_other, 1)
    next_off = 0;
    dl(SUB_OFFSET, 16'h0001, 16'h0001);
    dl(SUB_OFFSET, 16'h0001, 16'h0000);
    dl(SUB_ONE_PASS, 16'h0000, 16'($urandom));
    dl(SUB_OFFSET, 16'h0001, 16'h0000);
    do_reset();
    dl(SUB_OFFSET, 16'h0001, 16'h0001);
    report_and_stop();
  end
endmodule

/* tb/fwdl_host_dma.sv */
`timescale 1ns/1ns
module fwdl_host_dma
  import fwdl_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              load,
  input  wire logic [15:0]       sectors,
  input  wire logic              dma_ready,
  output logic [WORD_W-1:0]      dma_data,
  output logic                   dma_valid
);
  // ==========================================================
  // Host side DMA source
  logic [WORD_W-1:0] sent_q[$];
  int                left;
  int                taken;
  initial begin
    dma_valid = 1'b0;
    dma_data  = 32'h0;
    left      = 0;
    taken     = 0;
  end
  // Idle data toggles every cycle so a design that samples stale data cannot match by luck.
  always @(posedge core_clk) begin
    int rem;
    rem = load ? int'(sectors) * SECTOR_WORDS : left;
    if (reset) begin
      dma_valid <= 1'b0;
      left      <= 0;
    end else begin
      if (dma_valid && dma_ready) begin
        sent_q.push_back(dma_data);
        taken++;
      end
      if (!dma_valid || dma_ready) begin
        if (rem > 0 && ($urandom % 4) != 0) begin
          dma_valid <= 1'b1;
          dma_data  <= $urandom;
          rem--;
        end else begin
          dma_valid <= 1'b0;
          dma_data  <= ~dma_data;
        end
      end
      left <= rem;
    end
  end
endmodule
